// File: logic/mtrb_bank.sv
// mezzanine test register bank: control port, general word, sram bank pointers and flags
`include "mtrb_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module mtrb_bank #(
  parameter logic [31:0] BANK_DEPTH = `MTRB_DEF_DEPTH,
  parameter int          RST_CYC    = `MTRB_MEZZ_RST_CYC
) (
  // clock, reset, enable
  input  wire logic                clk_sys,
  input  wire logic                arst_n,
  input  wire logic                clk_en,
  // local bus
  input  wire mtrb_pkg::mtrb_req_t bus_req,
  output logic [31:0]              bus_rdata,
  output logic                     bus_rvalid,
  // 1-wire line
  input  wire logic                onewire_in,
  output logic                     onewire_out,
  output logic                     onewire_oe,
  // mezzanine jtag
  output mtrb_pkg::mtrb_jtag_t     jtag_out,
  input  wire logic                jtag_tdo,
  // mezzanine reset
  output logic                     mezzanine_reset_pulse,
  // memory banks
  input  wire logic                bank0_access,
  input  wire logic                bank1_access,
  output logic                     bank0_owner_select,
  output logic                     bank1_owner_select,
  output logic [31:0]              bank0_addr,
  output logic [31:0]              bank1_addr
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam logic [31:0] LAST_LOC = BANK_DEPTH - 32'h0000_0001;
  localparam logic [31:0] MID_LOC  = BANK_DEPTH >> 1;
  localparam logic [31:0] RST_LAST = 32'(RST_CYC - 1);

  function automatic logic reg_hit(input mtrb_pkg::mtrb_req_t r, input logic [7:0] ofs);
    return r.wr & (r.addr == ofs);
  endfunction

  function automatic logic [31:0] ptr_next(input logic [31:0] cur, input logic clr,
                                           input logic wr, input logic [31:0] wval,
                                           input logic step);
    logic [31:0] n;
    n = cur;
    if (clr)
      n = 32'h0000_0000;
    else if (wr)
      n = wval;
    else if (step)
      n = cur + 32'h0000_0001;
    return n;
  endfunction

  function automatic logic [3:0] flags_next(input logic [3:0] cur, input logic [31:0] p,
                                            input logic [31:0] thr, input logic wr,
                                            input logic wthr);
    logic [3:0] f;
    f = 4'h0;
    f[`MTRB_FL_ZERO] = (p == 32'h0000_0000);
    f[`MTRB_FL_END]  = (p >= LAST_LOC);
    f[`MTRB_FL_MID]  = (p >= MID_LOC);
    f[`MTRB_FL_THR]  = (p >= thr) | (cur[`MTRB_FL_THR] & ~(wr & ~wthr));
    return f;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] ow_sync_r;
  logic [1:0] tdo_sync_r;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      ow_sync_r  <= 2'h0;
      tdo_sync_r <= 2'h0;
    end
    else if (clk_en)
    begin
      ow_sync_r  <= {ow_sync_r[0], onewire_in};
      tdo_sync_r <= {tdo_sync_r[0], jtag_tdo};
    end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_cp;
  logic wr_gw;
  logic wr_bc;
  logic wr_p0;
  logic wr_p1;
  logic wr_t0;
  logic wr_t1;
  logic wr_fl;
  assign wr_cp = reg_hit(bus_req, `MTRB_OFS_CTRL_PORT);
  assign wr_gw = reg_hit(bus_req, `MTRB_OFS_GEN_WORD);
  assign wr_bc = reg_hit(bus_req, `MTRB_OFS_BANK_CTRL);
  assign wr_p0 = reg_hit(bus_req, `MTRB_OFS_B0_PTR);
  assign wr_p1 = reg_hit(bus_req, `MTRB_OFS_B1_PTR);
  assign wr_t0 = reg_hit(bus_req, `MTRB_OFS_B0_THR);
  assign wr_t1 = reg_hit(bus_req, `MTRB_OFS_B1_THR);
  assign wr_fl = reg_hit(bus_req, `MTRB_OFS_BANK_FLAGS);

  // ----------------------------------------------------------------
  // control port: 1-wire and jtag
  // ----------------------------------------------------------------
  logic line_r;
  logic dir_r;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      line_r <= 1'b0;
      dir_r  <= `MTRB_RST_DIR;
    end
    else if (clk_en && wr_cp)
    begin
      line_r <= bus_req.wdata[`MTRB_CP_LINE];
      dir_r  <= bus_req.wdata[`MTRB_CP_DIR];
    end

  // ----------------------------------------------------------------
  // jtag pins hold the last written levels
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      jtag_out <= '0;
    else if (clk_en && wr_cp)
    begin
      jtag_out.tdi <= bus_req.wdata[`MTRB_CP_TDI];
      jtag_out.tck <= bus_req.wdata[`MTRB_CP_TCK];
      jtag_out.tms <= bus_req.wdata[`MTRB_CP_TMS];
    end

  // dir low drives the line, dir high releases it
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      onewire_out <= 1'b0;
      onewire_oe  <= 1'b0;
    end
    else if (clk_en)
    begin
      onewire_out <= wr_cp ? bus_req.wdata[`MTRB_CP_LINE] : line_r;
      onewire_oe  <= wr_cp ? ~bus_req.wdata[`MTRB_CP_DIR] : ~dir_r;
    end

  // ----------------------------------------------------------------
  // mezzanine reset timer
  // ----------------------------------------------------------------
  mtrb_pkg::mtrb_rst_state_t rst_st_r;
  logic [31:0]               rst_cnt_r;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      rst_st_r              <= mtrb_pkg::MTRB_RST_IDLE;
      rst_cnt_r             <= 32'h0000_0000;
      mezzanine_reset_pulse <= 1'b0;
    end
    else if (clk_en)
    begin
      case (rst_st_r)
        mtrb_pkg::MTRB_RST_IDLE:
          if (wr_cp && bus_req.wdata[`MTRB_CP_RST])
          begin
            rst_st_r              <= mtrb_pkg::MTRB_RST_HOLD;
            rst_cnt_r             <= 32'h0000_0000;
            mezzanine_reset_pulse <= 1'b1;
          end
        mtrb_pkg::MTRB_RST_HOLD:
          if (rst_cnt_r == RST_LAST)
          begin
            rst_st_r              <= mtrb_pkg::MTRB_RST_IDLE;
            mezzanine_reset_pulse <= 1'b0;
          end
          else
            rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
        default:
        begin
          rst_st_r              <= mtrb_pkg::MTRB_RST_IDLE;
          mezzanine_reset_pulse <= 1'b0;
        end
      endcase
    end

  // ----------------------------------------------------------------
  // general word
  // ----------------------------------------------------------------
  logic [31:0] gen_word_r;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      gen_word_r <= `MTRB_RST_WORD;
    else if (clk_en && wr_gw)
      gen_word_r <= bus_req.wdata;

  // ----------------------------------------------------------------
  // bank control
  // ----------------------------------------------------------------
  logic b0_clr_r;
  logic b1_clr_r;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      bank0_owner_select <= 1'b0;
      b0_clr_r           <= 1'b0;
    end
    else if (clk_en && wr_bc)
    begin
      bank0_owner_select <= bus_req.wdata[`MTRB_BC_B0_OWN];
      b0_clr_r           <= bus_req.wdata[`MTRB_BC_B0_CLR];
    end

  // ----------------------------------------------------------------
  // bank 1 control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      bank1_owner_select <= 1'b0;
      b1_clr_r           <= 1'b0;
    end
    else if (clk_en && wr_bc)
    begin
      bank1_owner_select <= bus_req.wdata[`MTRB_BC_B1_OWN];
      b1_clr_r           <= bus_req.wdata[`MTRB_BC_B1_CLR];
    end

  // ----------------------------------------------------------------
  // bank 0 pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      bank0_addr <= 32'h0000_0000;
    else if (clk_en)
      bank0_addr <= ptr_next(bank0_addr, b0_clr_r, wr_p0, bus_req.wdata,
                             bank0_access & bank0_owner_select);

  // ----------------------------------------------------------------
  // bank 1 pointer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      bank1_addr <= 32'h0000_0000;
    else if (clk_en)
      bank1_addr <= ptr_next(bank1_addr, b1_clr_r, wr_p1, bus_req.wdata,
                             bank1_access & bank1_owner_select);

  // ----------------------------------------------------------------
  // thresholds
  // ----------------------------------------------------------------
  logic [31:0] b0_thr_r;
  logic [31:0] b1_thr_r;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      b0_thr_r <= 32'hFFFF_FFFF;
    else if (clk_en && wr_t0)
      b0_thr_r <= bus_req.wdata;

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      b1_thr_r <= 32'hFFFF_FFFF;
    else if (clk_en && wr_t1)
      b1_thr_r <= bus_req.wdata;

  // ----------------------------------------------------------------
  // bank flags: level flags follow the pointer, threshold flags stick
  // ----------------------------------------------------------------
  logic [3:0] b0_fl_r;
  logic [3:0] b1_fl_r;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      b0_fl_r <= 4'h1;
    else if (clk_en)
      b0_fl_r <= flags_next(b0_fl_r, bank0_addr, b0_thr_r, wr_fl,
                            bus_req.wdata[`MTRB_FL_THR]);

  // ----------------------------------------------------------------
  // bank 1 flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      b1_fl_r <= 4'h1;
    else if (clk_en)
      b1_fl_r <= flags_next(b1_fl_r, bank1_addr, b1_thr_r, wr_fl,
                            bus_req.wdata[`MTRB_FL_THR + `MTRB_FL_B1_SHIFT]);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (bus_req.addr)
      `MTRB_OFS_CTRL_PORT:
      begin
        rd_mux[`MTRB_CP_LINE] = ow_sync_r[1];
        rd_mux[`MTRB_CP_DIR]  = dir_r;
        rd_mux[`MTRB_CP_TDI]  = jtag_out.tdi;
        rd_mux[`MTRB_CP_TDO]  = tdo_sync_r[1];
        rd_mux[`MTRB_CP_TCK]  = jtag_out.tck;
        rd_mux[`MTRB_CP_TMS]  = jtag_out.tms;
        rd_mux[`MTRB_CP_RST]  = mezzanine_reset_pulse;
      end
      `MTRB_OFS_GEN_WORD:
        rd_mux = gen_word_r;
      `MTRB_OFS_BANK_CTRL:
        rd_mux[3:0] = {b1_clr_r, bank1_owner_select, b0_clr_r, bank0_owner_select};
      `MTRB_OFS_B0_PTR:
        rd_mux = bank0_addr;
      `MTRB_OFS_B1_PTR:
        rd_mux = bank1_addr;
      `MTRB_OFS_B0_THR:
        rd_mux = b0_thr_r;
      `MTRB_OFS_B1_THR:
        rd_mux = b1_thr_r;
      `MTRB_OFS_BANK_FLAGS:
        rd_mux[7:0] = {b1_fl_r, b0_fl_r};
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // read answer, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      bus_rdata  <= 32'h0000_0000;
      bus_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      bus_rvalid <= bus_req.rd;
      if (bus_req.rd)
        bus_rdata <= rd_mux;
    end
endmodule
`default_nettype wire

// File: logic/mtrb_cfg.svh
// register offsets, field positions and timing counts for the mezzanine test register bank
`ifndef MTRB_CFG_SVH
`define MTRB_CFG_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define MTRB_OFS_CTRL_PORT   8'h00
`define MTRB_OFS_GEN_WORD    8'h04
`define MTRB_OFS_BANK_CTRL   8'h08
`define MTRB_OFS_B0_PTR      8'h0C
`define MTRB_OFS_B1_PTR      8'h10
`define MTRB_OFS_B0_THR      8'h14
`define MTRB_OFS_B1_THR      8'h18
`define MTRB_OFS_BANK_FLAGS  8'h1C
// ----------------------------------------------------------------
// control port fields
// ----------------------------------------------------------------
`define MTRB_CP_LINE         0
`define MTRB_CP_DIR          1
`define MTRB_CP_TDI          16
`define MTRB_CP_TDO          17
`define MTRB_CP_TCK          18
`define MTRB_CP_TMS          19
`define MTRB_CP_RST          31
// ----------------------------------------------------------------
// bank control fields
// ----------------------------------------------------------------
`define MTRB_BC_B0_OWN       0
`define MTRB_BC_B0_CLR       1
`define MTRB_BC_B1_OWN       2
`define MTRB_BC_B1_CLR       3
// ----------------------------------------------------------------
// bank flag fields (bank 1 sits four bits higher)
// ----------------------------------------------------------------
`define MTRB_FL_ZERO         0
`define MTRB_FL_END          1
`define MTRB_FL_MID          2
`define MTRB_FL_THR          3
`define MTRB_FL_B1_SHIFT     4
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define MTRB_RST_WORD        32'h0000_0000
`define MTRB_RST_DIR         1'b1
`define MTRB_MEZZ_RST_MS     100
`define MTRB_CLK_HZ          100000000
`define MTRB_MEZZ_RST_CYC    (`MTRB_MEZZ_RST_MS * (`MTRB_CLK_HZ / 1000))
`define MTRB_DEF_DEPTH       32'h0004_0000
`endif

// File: logic/mtrb_pkg.sv
// types shared by the mezzanine test register bank
package mtrb_pkg;
  // ----------------------------------------------------------------
  // local bus request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mtrb_req_t;
  // ----------------------------------------------------------------
  // mezzanine jtag drive
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tdi;
    logic tck;
    logic tms;
  } mtrb_jtag_t;
  // ----------------------------------------------------------------
  // reset pulse state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    MTRB_RST_IDLE = 1'b0,
    MTRB_RST_HOLD = 1'b1
  } mtrb_rst_state_t;
endpackage

// File: tb/mtrb_bank_asserts.sv
// port checker for the mezzanine test register bank
`timescale 1ns/10ps
`default_nettype none
module mtrb_bank_asserts #(
  parameter logic [31:0] BANK_DEPTH = 32'h0000_0040,
  parameter int          RST_CYC    = 20
) (
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 arst_n,
  input wire logic                 clk_en,
  // bus and pins
  input wire mtrb_pkg::mtrb_req_t  bus_req,
  input wire logic                 bus_rvalid,
  input wire logic                 onewire_out,
  input wire logic                 onewire_oe,
  input wire mtrb_pkg::mtrb_jtag_t jtag_out,
  input wire logic                 mezzanine_reset_pulse,
  // banks
  input wire logic                 bank0_access,
  input wire logic                 bank0_owner_select,
  input wire logic                 bank1_owner_select,
  input wire logic [31:0]          bank0_addr,
  input wire logic [31:0]          bank1_addr
);
  logic wr0;
  logic wr8;
  logic clr0_r;
  int   hi_cnt_r;
  // ----------------
  // helpers
  // ----------------
  assign wr0 = clk_en && bus_req.wr && bus_req.addr == 8'h00;
  assign wr8 = clk_en && bus_req.wr && bus_req.addr == 8'h08;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      clr0_r   <= 1'b0;
      hi_cnt_r <= 0;
    end
    else if (clk_en)
    begin
      if (wr8)
        clr0_r <= bus_req.wdata[1];
      hi_cnt_r <= mezzanine_reset_pulse ? hi_cnt_r + 1 : 0;
    end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // ----------------
  // assertions
  // ----------------
  a_read_answer: assert property (clk_en && bus_req.rd |=> bus_rvalid)
    else $error("read not answered");
  a_no_read: assert property (clk_en && !bus_req.rd |=> !bus_rvalid)
    else $error("answer without read");
  a_line_drive: assert property (
    wr0 |=> onewire_oe == !$past(bus_req.wdata[1]) && onewire_out == $past(bus_req.wdata[0]))
    else $error("1-wire drive wrong");
  a_jtag_pins: assert property (wr0 |=> jtag_out ==
    {$past(bus_req.wdata[16]), $past(bus_req.wdata[18]), $past(bus_req.wdata[19])})
    else $error("jtag pins wrong");
  a_rst_start: assert property (
    wr0 && bus_req.wdata[31] && !mezzanine_reset_pulse |=> mezzanine_reset_pulse [*8])
    else $error("reset pulse not started");
  a_rst_length: assert property ($fell(mezzanine_reset_pulse) |-> hi_cnt_r == RST_CYC)
    else $error("reset pulse length wrong");
  a_owner_sel: assert property (wr8 |=>
    bank0_owner_select == $past(bus_req.wdata[0]) && bank1_owner_select == $past(bus_req.wdata[2]))
    else $error("owner select wrong");
  a_ptr0_clear: assert property (wr8 && bus_req.wdata[1] |-> ##[1:2] bank0_addr == 32'h0)
    else $error("bank 0 pointer not cleared");
  a_ptr1_clear: assert property (wr8 && bus_req.wdata[3] |-> ##[1:2] bank1_addr == 32'h0)
    else $error("bank 1 pointer not cleared");
  a_ptr_step: assert property (
    clk_en && bank0_owner_select && bank0_access && !bus_req.wr && !clr0_r
    |=> bank0_addr == $past(bank0_addr) + 32'h1)
    else $error("bank 0 pointer did not step");
  a_ptr_hold: assert property (
    clk_en && !bank0_owner_select && !bus_req.wr && !clr0_r |=> $stable(bank0_addr))
    else $error("unowned bank 0 pointer moved");
endmodule
`default_nettype wire

// File: tb/mtrb_mezz_model.sv
// mezzanine card model: 1-wire line, one-cell jtag chain, bank accesses
`timescale 1ns/10ps
`default_nettype none
module mtrb_mezz_model (
  // from the bank
  input  wire logic                 onewire_out,
  input  wire logic                 onewire_oe,
  input  wire mtrb_pkg::mtrb_jtag_t jtag_out,
  // bench commands
  input  wire logic                 eep_pull,
  input  wire logic [1:0]           acc_req,
  // back to the bank
  output logic                      onewire_in,
  output logic                      jtag_tdo,
  output logic                      bank0_access,
  output logic                      bank1_access
);
  logic cap_r = 1'b0;
  logic tdo_r = 1'b0;
  // wired line with pull-up, low if either side pulls
  assign onewire_in = !((onewire_oe && !onewire_out) || eep_pull);
  // capture on tck rise, shift out on fall
  always @(posedge jtag_out.tck) cap_r <= jtag_out.tdi;
  always @(negedge jtag_out.tck) tdo_r <= cap_r;
  assign jtag_tdo = tdo_r;
  // one pulse per card access by the pointer
  assign bank0_access = acc_req[0];
  assign bank1_access = acc_req[1];
endmodule
`default_nettype wire

// File: tb/testbench.sv
// bench for the mezzanine test register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [31:0] DEPTH = 32'h0000_0040;
  localparam int          RCYC  = 20;
  localparam logic [31:0] RST_EXP [8] = '{32'h3, 32'h0, 32'h0, 32'h0, 32'h0,
                                           32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h11};
  localparam logic [31:0] EDGE_PTR [4] = '{DEPTH / 2 - 1, DEPTH / 2, DEPTH - 2, DEPTH - 1};
  logic                 clk_sys, arst_n, clk_en, bus_rvalid, onewire_in, onewire_out;
  logic                 onewire_oe, jtag_tdo, mezzanine_reset_pulse, eep_pull;
  logic                 bank0_access, bank1_access, bank0_owner_select, bank1_owner_select;
  logic [1:0]           acc_req;
  logic [31:0]          bus_rdata, bank0_addr, bank1_addr, v, p;
  mtrb_pkg::mtrb_req_t  bus_req;
  mtrb_pkg::mtrb_jtag_t jtag_out;
  int                   miscompares, n_tests, i, b;
  // ----------------
  // design and card
  // ----------------
  mtrb_bank #(.BANK_DEPTH(DEPTH), .RST_CYC(RCYC)) mtrb_bank_inst (.clk_sys, .arst_n, .clk_en,
    .bus_req, .bus_rdata, .bus_rvalid, .onewire_in, .onewire_out, .onewire_oe, .jtag_out,
    .jtag_tdo, .mezzanine_reset_pulse, .bank0_access, .bank1_access, .bank0_owner_select,
    .bank1_owner_select, .bank0_addr, .bank1_addr);
  mtrb_mezz_model mtrb_mezz_model_inst (.onewire_out, .onewire_oe, .jtag_out, .eep_pull,
    .acc_req, .onewire_in, .jtag_tdo, .bank0_access, .bank1_access);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------
  // tasks
  // ----------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_req.wr = 1'b1;
    bus_req.addr = a;
    bus_req.wdata = d;
    idle(1);
    bus_req.wr = 1'b0;
    idle(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    int k;
    bus_req.rd = 1'b1;
    bus_req.addr = a;
    idle(1);
    bus_req.rd = 1'b0;
    for (k = 0; k < 4 && bus_rvalid !== 1'b1; k++)
      idle(1);
    chk($sformatf("reg %h", a), e, bus_rdata);
    idle(1);
  endtask
  task automatic step(input int k, input int n);
    acc_req[k] = 1'b1;
    idle(n);
    acc_req[k] = 1'b0;
    idle(1);
  endtask
  function automatic logic [31:0] flg(input logic [31:0] q, input logic t, input int k);
    return ({28'h0, t, q >= DEPTH / 2, q >= DEPTH - 1, q == 32'h0} << (4 * k))
           | (k != 0 ? 32'h01 : 32'h10);
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    report_and_stop();
  end
  // ----------------
  // tests
  // ----------------
  initial
  begin
    bus_req = '0;
    clk_en = 1'b1;
    arst_n = 1'b0;
    eep_pull = 1'b0;
    acc_req = 2'h0;
    miscompares = 0;
    n_tests = 0;
    v = $urandom(37);
    repeat (2) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    idle(4);
    for (i = 0; i < 8; i++)
      rc(8'(4 * i), RST_EXP[i]);
    wr(8'h20, 32'hFFFF_FFFF);
    rc(8'h20, 32'h0);
    wr(8'h08, 32'hFFFF_FFF0);
    rc(8'h08, 32'h0);
    for (i = 0; i < 6; i++)
    begin
      v = $urandom;
      wr(8'h04, v);
      rc(8'h04, v);
    end
    $display("test map done");
    for (i = 0; i < 2; i++)
    begin
      eep_pull = i[0];
      wr(8'h00, 32'h2);
      idle(3);
      rc(8'h00, {31'h1, !i[0]});
      eep_pull = 1'b0;
      wr(8'h00, 32'(i));
      idle(3);
      rc(8'h00, 32'(i));
    end
    for (i = 0; i < 4; i++)
    begin
      v = $urandom & 32'h0009_0000;
      wr(8'h00, v);
      wr(8'h00, v | 32'h0006_0000);
      chk("jtag pins", {29'h0, v[16], 1'b1, v[19]}, {29'h0, jtag_out});
      wr(8'h00, v);
      idle(3);
      rc(8'h00, v | (32'(v[16]) << 17));
    end
    wr(8'h00, 32'h8000_0000);
    rc(8'h00, 32'h8000_0000 | (32'(v[16]) << 17));
    for (i = 0; i < RCYC + 5 && mezzanine_reset_pulse === 1'b1; i++)
      idle(1);
    rc(8'h00, 32'(v[16]) << 17);
    $display("test pins done");
    for (b = 0; b < 2; b++)
    begin
      p = 32'($urandom % 28) + 32'h1;
      wr(8'h08, 32'h0);
      wr(8'h0C + 8'(4 * b), p);
      wr(8'h14 + 8'(4 * b), p + 32'h2);
      step(b, 2);
      rc(8'h0C + 8'(4 * b), p);
      wr(8'h08, 32'h1 << (2 * b));
      step(b, 4);
      clk_en = 1'b0;
      step(b, 2);
      clk_en = 1'b1;
      p = p + 32'h4;
      rc(8'h0C + 8'(4 * b), p);
      rc(8'h1C, flg(p, 1'b1, b));
      wr(8'h14 + 8'(4 * b), 32'hFFFF_FFFF);
      wr(8'h1C, 32'hFF);
      rc(8'h1C, flg(p, 1'b1, b));
      wr(8'h1C, 32'h0);
      rc(8'h1C, flg(p, 1'b0, b));
      foreach (EDGE_PTR[j])
      begin
        wr(8'h0C + 8'(4 * b), EDGE_PTR[j]);
        rc(8'h1C, flg(EDGE_PTR[j], 1'b0, b));
      end
      wr(8'h08, 32'h3 << (2 * b));
      step(b, 2);
      rc(8'h0C + 8'(4 * b), 32'h0);
      rc(8'h1C, 32'h11);
      $display("test bank %0d done", b);
    end
    report_and_stop();
  end
endmodule
bind mtrb_bank mtrb_bank_asserts #(.BANK_DEPTH(BANK_DEPTH), .RST_CYC(RST_CYC))
  mtrb_bank_asserts_inst (.clk_sys, .arst_n, .clk_en, .bus_req, .bus_rvalid, .onewire_out,
  .onewire_oe, .jtag_out, .mezzanine_reset_pulse, .bank0_access, .bank0_owner_select,
  .bank1_owner_select, .bank0_addr, .bank1_addr);
`default_nettype wire
